// *** ats_defines.vh ***
// ats_defines.vh: constants for the converter trim and test pattern registers
// assumes inclusion by bare name from the design files
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH
`define ATS_ADDR_W 3
`define ATS_DATA_W 16
`define ATS_FRAME_LEN 5'h14
`define ATS_ADDR_CTRL 3'h0
`define ATS_ADDR_OFFSET 3'h2
`define ATS_ADDR_ADJUST 3'h4
`define ATS_ADDR_PATTERN 3'h5
`define ATS_OFFSET_RST 8'h80
`define ATS_LEVEL_RST 5'h10
`define ATS_SETTLE_RST 2'h0
`define ATS_DUTY_RST 3'h0
`define ATS_PATTERN_RST 12'h000
`define ATS_CTRL_TEST_BIT 7
`define ATS_LEVEL_LSB 0
`define ATS_LEVEL_MSB 4
`define ATS_SETTLE_LSB 8
`define ATS_SETTLE_MSB 9
`define ATS_DUTY_LSB 13
`define ATS_DUTY_MSB 15
`define ATS_OFFSET_MSB 7
`define ATS_PATTERN_MSB 11
`endif

// *** ats_sync.v ***
// ats_sync.v: two-flop synchroniser for a vector of pins
// assumes inputs are asynchronous to i_ref_clk
`timescale 1ns/1ps
module ats_sync #(
  parameter WIDTH = 4
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_r <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// *** ats_regs.v ***
// ats_regs.v: trim and test pattern registers loaded over the serial port
// assumes the serial clock is much slower than i_ref_clk (>= 4 samples/phase)
`timescale 1ns/1ps
`include "ats_defines.vh"
module ats_regs #(
  parameter SAMPLE_W = 12
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_sclk,
  input wire i_sload_n,
  input wire i_sdata,
  input wire i_smode,
  input wire i_sample_valid,
  input wire [SAMPLE_W-1:0] i_sample,
  output reg [SAMPLE_W-1:0] o_true_lanes,
  output reg [SAMPLE_W-1:0] o_inverted_output_lanes,
  output reg o_lanes_valid,
  output reg [7:0] o_offset_trim,
  output reg [4:0] o_level_shift_trim,
  output reg [1:0] o_settling_delay_trim,
  output reg [2:0] o_duty_ratio,
  output reg o_test_mode
);
  wire [3:0] pins_sync;
  wire sclk_s;
  wire sload_n_s;
  wire sdata_s;
  wire smode_s;
  reg sclk_d_r;
  reg [4:0] cnt_r;
  reg [18:0] shift_r;
  reg [11:0] pattern_r;
  wire sclk_rise;
  wire [`ATS_ADDR_W-1:0] addr;
  wire [`ATS_DATA_W-1:0] data;
  wire load;
  // next values of the frame receiver
  reg [4:0] cnt_nxt;
  reg [18:0] shift_nxt;
  // next values of the stored fields
  reg [7:0] offset_nxt;
  reg [4:0] level_nxt;
  reg [1:0] settle_nxt;
  reg [2:0] duty_nxt;
  reg [11:0] pattern_nxt;
  reg test_nxt;
  // next value of the true lanes; the inverted lanes follow from it
  reg [SAMPLE_W-1:0] true_nxt;

  // pins enter through two flops before anything reads them
  ats_sync #(.WIDTH(4)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_sclk, i_sload_n, i_sdata, i_smode}),
    .o_sync(pins_sync)
  );
  assign sclk_s = pins_sync[3];
  assign sload_n_s = pins_sync[2];
  assign sdata_s = pins_sync[1];
  assign smode_s = pins_sync[0];
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign addr = shift_r[18:16];
  assign data = shift_r[15:0];
  // count 19 bits then transfer on the 20th low cycle; later ones ignored
  assign load = sclk_rise & ~sload_n_s &
    (cnt_r == `ATS_FRAME_LEN - 5'h1);

  // frame receiver: one step per detected serial clock rise
  always @* begin
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    if (sclk_rise) begin
      if (sload_n_s) begin
        cnt_nxt = 5'h00; // a high cycle aborts a partial frame
      end else if (cnt_r < `ATS_FRAME_LEN - 5'h1) begin
        shift_nxt = {shift_r[17:0], sdata_s};
        cnt_nxt = cnt_r + 5'h01;
      end else if (cnt_r == `ATS_FRAME_LEN - 5'h1) begin
        // parking at the full count makes extra low cycles harmless
        cnt_nxt = `ATS_FRAME_LEN;
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
      cnt_r <= 5'h00;
      shift_r <= 19'h00000;
    end else begin
      sclk_d_r <= sclk_s;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  // only the addressed register moves; all others keep their value
  always @* begin
    offset_nxt = o_offset_trim;
    level_nxt = o_level_shift_trim;
    settle_nxt = o_settling_delay_trim;
    duty_nxt = o_duty_ratio;
    pattern_nxt = pattern_r;
    test_nxt = o_test_mode;
    if (load) begin
      case (addr)
        `ATS_ADDR_CTRL: begin
          // other control bits belong to logic outside this block
          test_nxt = data[`ATS_CTRL_TEST_BIT];
        end
        `ATS_ADDR_OFFSET: begin
          // code goes to the analog trim as is; polarity is analog side
          offset_nxt = data[`ATS_OFFSET_MSB:0];
        end
        `ATS_ADDR_ADJUST: begin
          level_nxt = data[`ATS_LEVEL_MSB:`ATS_LEVEL_LSB];
          settle_nxt =
            data[`ATS_SETTLE_MSB:`ATS_SETTLE_LSB];
          // undefined duty codes are kept, not coerced
          duty_nxt = data[`ATS_DUTY_MSB:`ATS_DUTY_LSB];
        end
        `ATS_ADDR_PATTERN: begin
          pattern_nxt = data[`ATS_PATTERN_MSB:0];
        end
        default: begin
          // unused addresses are accepted and dropped
        end
      endcase
    end
  end

  // mode pin low returns registers to their reset values regardless of frame traffic
  always @(posedge i_ref_clk) begin
    if (i_rst || !smode_s) begin
      o_offset_trim <= `ATS_OFFSET_RST;
      o_level_shift_trim <= `ATS_LEVEL_RST;
      o_settling_delay_trim <= `ATS_SETTLE_RST;
      o_duty_ratio <= `ATS_DUTY_RST;
      pattern_r <= `ATS_PATTERN_RST;
      o_test_mode <= 1'b0;
    end else begin
      o_offset_trim <= offset_nxt;
      o_level_shift_trim <= level_nxt;
      o_settling_delay_trim <= settle_nxt;
      o_duty_ratio <= duty_nxt;
      pattern_r <= pattern_nxt;
      o_test_mode <= test_nxt;
    end
  end

  // lanes change only on a sample strobe, so the pattern stays static
  always @* begin
    true_nxt = o_true_lanes;
    if (i_sample_valid) begin
      if (o_test_mode) begin
        true_nxt = pattern_r[SAMPLE_W-1:0];
      end else begin
        true_nxt = i_sample;
      end
    end
  end

  // both lane sets come from flops fed by one next value, so they
  // can never disagree for a cycle
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_true_lanes <= {SAMPLE_W{1'b0}};
      o_inverted_output_lanes <= {SAMPLE_W{1'b1}};
      o_lanes_valid <= 1'b0;
    end else begin
      o_lanes_valid <= i_sample_valid;
      o_true_lanes <= true_nxt;
      o_inverted_output_lanes <= ~true_nxt;
    end
  end
endmodule

// *** ats_regs_properties.sv ***
// ats_regs_properties.sv: port checks for ats_regs
// assumes sync reset i_rst on i_ref_clk
`timescale 1ns/1ps
module ats_regs_chk #(parameter SAMPLE_W=12) (
  input wire i_ref_clk,i_rst,i_smode,i_sload_n,i_sample_valid,
  input wire o_lanes_valid,o_test_mode,
  input wire [SAMPLE_W-1:0] i_sample,o_true_lanes,o_inverted_output_lanes,
  input wire [7:0] o_offset_trim,
  input wire [4:0] o_level_shift_trim,
  input wire [1:0] o_settling_delay_trim,
  input wire [2:0] o_duty_ratio);
  wire [18:0] tr={o_offset_trim,o_level_shift_trim,o_settling_delay_trim,
    o_duty_ratio,o_test_mode};
  wire dflt=tr==19'h40400;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_inv; o_inverted_output_lanes==~o_true_lanes; endproperty
  a_inv: assert property(p_inv) else $error("complement");
  property p_rst; $past(i_rst) |-> dflt; endproperty
  a_rst: assert property(p_rst) else $error("reset");
  property p_mode; !i_smode[*4] |-> dflt; endproperty
  a_mode: assert property(p_mode) else $error("mode");
  // writes only land inside a frame, so a long idle stretch moves nothing
  property p_idle; (i_sload_n&&i_smode)[*6] |=> $stable(tr); endproperty
  a_idle: assert property(p_idle) else $error("idle");
  property p_vld; i_sample_valid |=> o_lanes_valid; endproperty
  a_vld: assert property(p_vld) else $error("valid");
  property p_hold; !i_sample_valid |=> $stable(o_true_lanes); endproperty
  a_hold: assert property(p_hold) else $error("hold");
  property p_pass;
    !o_test_mode&&i_sample_valid |=> o_true_lanes==$past(i_sample);
  endproperty
  a_pass: assert property(p_pass) else $error("pass");
  property p_pat;
    (o_test_mode&&i_sample_valid)[*2] |=> $stable(o_true_lanes);
  endproperty
  a_pat: assert property(p_pat) else $error("pattern");
  c_tm: cover property(o_test_mode&&o_lanes_valid);
  c_md: cover property(!i_smode[*4]);
  c_du: cover property($changed(o_duty_ratio));
endmodule
bind ats_regs ats_regs_chk #(.SAMPLE_W(SAMPLE_W)) ats_regs_chk_i(.*);

// *** ats_ctrl_model.sv ***
// ats_ctrl_model.sv: serial write controller
// assumes 125 ns serial clock, idle low between frames
`timescale 1ns/1ps
module ats_ctrl_model(output logic o_sclk=0,o_sload_n=1,o_sdata=0);
  // n under 20 ends the frame early and the write is lost
  task automatic send(input logic [18:0] w,input int n);
    for(int i=0;i<=n+1;i++) begin
      o_sload_n=i==0||i>n;
      o_sdata=i>0&&i<20?w[19-i]:~o_sdata;
      #62.5 o_sclk=1;
      #62.5 o_sclk=0;
    end
  endtask
endmodule

// *** tb_ats_regs.sv ***
// tb_ats_regs.sv: self-checking bench for ats_regs
// assumes the model and checker files are compiled first
`timescale 1ns/1ps
module tb_ats_regs;
  logic i_ref_clk=0,i_rst=1,i_smode=1,i_sample_valid=0;
  logic [11:0] i_sample=0;
  wire sck,sld_n,sd,vld,tm;
  wire [11:0] tl,il;
  wire [7:0] off;
  wire [4:0] lv;
  wire [1:0] st;
  wire [2:0] du;
  wire [18:0] tr={off,lv,st,du,tm};
  int bad_count=0,comparisons=0,cyc=0;
  always #5 i_ref_clk=~i_ref_clk;
  ats_ctrl_model ats_ctrl_model_i(.o_sclk(sck),.o_sload_n(sld_n),.o_sdata(sd));
  ats_regs ats_regs_i(.i_ref_clk(i_ref_clk),.i_rst(i_rst),.i_sclk(sck),
    .i_sload_n(sld_n),.i_sdata(sd),.i_smode(i_smode),
    .i_sample_valid(i_sample_valid),.i_sample(i_sample),.o_true_lanes(tl),
    .o_inverted_output_lanes(il),.o_lanes_valid(vld),.o_offset_trim(off),
    .o_level_shift_trim(lv),.o_settling_delay_trim(st),.o_duty_ratio(du),
    .o_test_mode(tm));
  task automatic chk(input string s,input logic [24:0] e,g);
    comparisons++;
    if(g!==e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h",s,e,g);
    end
  endtask
  task automatic w(input logic [18:0] f,input int n=20);
    ats_ctrl_model_i.send(f,n);
  endtask
  task automatic smp(input logic [11:0] s,e);
    @(negedge i_ref_clk) {i_sample_valid,i_sample}={1'b1,~s};
    @(negedge i_ref_clk) i_sample=s;
    @(negedge i_ref_clk) i_sample_valid=0;
    chk("lanes",{1'b1,e,e},{vld,~il,tl});
  endtask
  task finish_test;
    if(bad_count==0&&comparisons>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_ref_clk) if(++cyc==20000) begin
    bad_count++;
    finish_test;
  end
  initial begin
    repeat(3) @(negedge i_ref_clk);
    i_rst=0;
    repeat(3) @(negedge i_ref_clk);
    chk("reset",{8'h80,11'h400},tr);
    w({3'h2,16'hFF3C});
    chk("offset",{8'h3C,11'h400},tr);
    for(int k=0;k<4;k++) begin
      w({3'h4,3'(k*2),3'h7,2'(k),3'h7,5'(k*10+1)});
      chk("adjust",{8'h3C,5'(k*10+1),2'(k),3'(k*2),1'b0},tr);
    end
    w({3'h2,16'h0011},10);
    w({3'h3,16'hFFFF});
    chk("ignored",{8'h3C,5'h1F,2'h3,3'h6,1'b0},tr);
    w({3'h5,16'hFAAA});
    smp(12'h123,12'h123);
    w({3'h0,16'h0080});
    smp(12'h123,12'hAAA);
    @(negedge i_ref_clk) i_smode=0;
    repeat(6) @(negedge i_ref_clk);
    chk("mode",{8'h80,11'h400},tr);
    i_smode=1;
    smp(12'h5C3,12'h5C3);
    finish_test;
  end
endmodule
